/* File: include/pwm_ctl_pkg.sv */
// Overview of operation
// - Clock select 0 drives modulators externally.
// - External prescale divides by 256 or 512.
// - Simultaneous enables start both modulators aligned.
// - Monitor external clock when selected and enabled.
// - Bad clock ignored, fault pin, failure flag.
// - Recover after flag read and clock good.
// - Calibration command arms period measurement.
// - Time select low pulse, set period.
// - Internal switching period is 256 ticks.
// - Out-of-window pulse keeps previous period.
// - Parallel mirrors bank 0 except diag bits.
// - Parallel readback copied whenever it differs from bank 0.
// - Bits OD3 to OD5 stay per channel.
// - Openload flags per channel, own enables.
// - Parallel uses channel 0 sense ratio.
// - Battery short per channel, gated by D8.
// - Parallel overcurrent: both off, both flags.
// - Parallel short and overtemp: both off, flags.
// - Shared retry counter, channel 0 delatches both.
// - Overtemp sets flag, pin low, channel off.
// - Pin low until cool and turn-on.
// - Overtemp flag clears only cool, pin high.
// - Off when bit 0, duty (n+1)/256, full on.
// - Clock select 1 uses internal oscillator.
// - Pin real time, flags sticky until read.
package pwm_ctl_pkg;
  localparam int CLK_PERIOD_NS = 20;
  localparam int EXT_PERIOD_MIN_NS = 40;
  localparam int EXT_PERIOD_MAX_NS = 2000;
  localparam int CSB_MIN_NS = 20000;
  localparam int CSB_MAX_NS = 60000;
  localparam int INT_PERIOD_DEF_NS = 39000;
  localparam int CNT_W = 12;
  // Least times round up, longest round down
  localparam int EXT_MIN_CYC = (EXT_PERIOD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_MAX_CYC = EXT_PERIOD_MAX_NS / CLK_PERIOD_NS;
  localparam int CSB_MIN_CYC = (CSB_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSB_MAX_CYC = CSB_MAX_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] INT_PERIOD_DEF = CNT_W'(INT_PERIOD_DEF_NS / CLK_PERIOD_NS);
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [3:0] RETRY_ZERO = 4'h0;
  // Fault flag positions
  localparam int OD_OC = 0;
  localparam int OD_SC = 1;
  localparam int OD_OT = 2;
  localparam int OD_OS = 3;
  localparam int OD_OLA = 4;
  localparam int OD_OLI = 5;
  localparam int FLAG_W = 6;
  // Diagnostic config field (D6, D7, D8)
  localparam int CFG_OLI = 0;
  localparam int CFG_OLA = 1;
  localparam int CFG_OS = 2;
  typedef enum logic [1:0] {CAL_IDLE, CAL_ARMED, CAL_MEASURE} cal_state_e;
endpackage

/* File: src/dual_switch_pwm_clock_parallel.sv */
`timescale 1ns/1ps
module dual_switch_pwm_clock_parallel
  import pwm_ctl_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              extClock,
  input  wire logic              chipSelectPinN,
  input  wire logic              calibrationCmd,
  input  wire logic              parallelMode,
  input  wire logic              channelOnCh0,
  input  wire logic              channelOnCh1,
  input  wire logic              pwmEnableCh0,
  input  wire logic              pwmEnableCh1,
  input  wire logic              clockIntCh0,
  input  wire logic              clockIntCh1,
  input  wire logic              prescaleDoubleCh0,
  input  wire logic              prescaleDoubleCh1,
  input  wire logic              senseRatioCh0,
  input  wire logic              senseRatioCh1,
  input  wire logic [7:0]        dutyCh0,
  input  wire logic [7:0]        dutyCh1,
  input  wire logic [2:0]        diagCfgCh0,
  input  wire logic [2:0]        diagCfgCh1,
  input  wire logic              autoRetryCh0,
  input  wire logic              autoRetryCh1,
  input  wire logic [3:0]        retryLimitCh0,
  input  wire logic [3:0]        retryLimitCh1,
  input  wire logic [1:0]        overtempIn,
  input  wire logic [1:0]        overcurrentIn,
  input  wire logic [1:0]        severeShortIn,
  input  wire logic [1:0]        batteryShortIn,
  input  wire logic [1:0]        openloadActiveIn,
  input  wire logic [1:0]        openloadIdleIn,
  input  wire logic              faultRegReadCh0,
  input  wire logic              faultRegReadCh1,
  input  wire logic              diagRegRead,
  output logic                   outputCh0,
  output logic                   outputCh1,
  output logic                   faultPinN,
  output logic [FLAG_W-1:0]      faultFlagsCh0,
  output logic [FLAG_W-1:0]      faultFlagsCh1,
  output logic                   extClockFailFlag,
  output logic [3:0]             retryCountCh0,
  output logic [3:0]             retryCountCh1,
  output logic                   senseRatioEffCh1,
  output logic [CNT_W-1:0]       intPeriod
);
  cal_state_e       calState_reg;
  logic [CNT_W-1:0] csCnt_reg;
  logic [CNT_W-1:0] extCnt_reg;
  logic             csPrev_reg;
  logic             extPrev_reg;
  logic             extInRange_reg;
  logic             extFail_reg;
  logic             readSeen_reg;
  logic             otHold_reg;
  logic [1:0]       onPrev_reg;
  logic [1:0]       latched_reg;
  logic [3:0]       retry1_reg;
  logic             csFall;
  logic             csRise;
  logic             extRise;
  logic             monitorOn;
  logic             extBad;
  logic [1:0]       chOn;
  logic [1:0]       onRise;
  logic [1:0]       ocEff;
  logic [1:0]       scEff;
  logic [1:0]       otEff;
  logic [1:0]       trip;
  logic [1:0]       delatch;
  logic [1:0]       retryEvt;
  logic [1:0]       forceOff;
  logic [FLAG_W-1:0] set0;
  logic [FLAG_W-1:0] set1;

  // Window check shared by both monitors
  function automatic logic inWindow(input logic [CNT_W-1:0] v, input int lo, input int hi);
    inWindow = (v >= CNT_W'(lo)) && (v <= CNT_W'(hi));
  endfunction

  // Fault flag update: set wins over clear on read
  function automatic logic [FLAG_W-1:0] flagNext(input logic [FLAG_W-1:0] cur,
      input logic [FLAG_W-1:0] set, input logic [FLAG_W-1:0] clr);
    flagNext = set | (cur & ~clr);
  endfunction

  // Edges of the sampled pins
  assign csFall  = csPrev_reg & ~chipSelectPinN;
  assign csRise  = ~csPrev_reg & chipSelectPinN;
  assign extRise = ~extPrev_reg & extClock;
  assign chOn    = {channelOnCh1, channelOnCh0};
  assign onRise  = chOn & ~onPrev_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      csPrev_reg  <= 1'b1;
      extPrev_reg <= 1'b0;
      onPrev_reg  <= 2'b00;
    end else begin
      csPrev_reg  <= chipSelectPinN;
      extPrev_reg <= extClock;
      onPrev_reg  <= chOn;
    end
  end

  // Calibration sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      calState_reg <= CAL_IDLE;
      csCnt_reg    <= '0;
      intPeriod    <= INT_PERIOD_DEF;
    end else begin
      unique case (calState_reg)
        CAL_IDLE: begin
          if (calibrationCmd) begin
            calState_reg <= CAL_ARMED;
          end
        end
        CAL_ARMED: begin
          if (csFall) begin
            calState_reg <= CAL_MEASURE;
            csCnt_reg    <= CNT_W'(1);
          end
        end
        CAL_MEASURE: begin
          if (csRise) begin
            calState_reg <= CAL_IDLE;
            if (inWindow(csCnt_reg, CSB_MIN_CYC, CSB_MAX_CYC)) begin
              intPeriod <= csCnt_reg;
            end // else kept
          end else if (csCnt_reg <= CNT_W'(CSB_MAX_CYC)) begin
            csCnt_reg <= csCnt_reg + CNT_W'(1);
          end
        end
      endcase
    end
  end

  // External clock period monitor
  assign monitorOn = (~clockIntCh0 & pwmEnableCh0) |
                     (~parallelMode & ~clockIntCh1 & pwmEnableCh1);
  assign extBad    = monitorOn & ~extInRange_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      extCnt_reg     <= '0;
      extInRange_reg <= 1'b1;
    end else if (extRise) begin
      extCnt_reg     <= CNT_W'(1);
      extInRange_reg <= inWindow(extCnt_reg, EXT_MIN_CYC, EXT_MAX_CYC);
    end else if (extCnt_reg > CNT_W'(EXT_MAX_CYC)) begin
      extInRange_reg <= 1'b0;
    end else begin
      extCnt_reg <= extCnt_reg + CNT_W'(1);
    end
  end

  // Clock failure state and its recovery
  always_ff @(posedge clk) begin
    if (rst) begin
      extFail_reg      <= 1'b0;
      readSeen_reg     <= 1'b0;
      extClockFailFlag <= 1'b0;
    end else begin
      if (extBad) begin
        extFail_reg <= 1'b1;
      end else if (readSeen_reg && extInRange_reg) begin
        extFail_reg <= 1'b0;
      end
      if (extBad && !extFail_reg) begin
        readSeen_reg <= 1'b0;
      end else if (diagRegRead && extFail_reg) begin
        readSeen_reg <= 1'b1;
      end else if (!extFail_reg) begin
        readSeen_reg <= 1'b0;
      end
      extClockFailFlag <= extBad | (extClockFailFlag & ~diagRegRead);
    end
  end

  // Fault coupling across channels in parallel mode
  assign ocEff = parallelMode ? {2{|overcurrentIn}} : overcurrentIn;
  assign scEff = parallelMode ? {2{|severeShortIn}} : severeShortIn;
  assign otEff = parallelMode ? {2{|overtempIn}} : overtempIn;
  assign trip  = ocEff | scEff | otEff;

  // Auto-retry and delatch, channel 0 governs both in parallel mode
  assign retryEvt[0] = latched_reg[0] & ~trip[0] & autoRetryCh0 &
                       (retryCountCh0 != retryLimitCh0);
  assign retryEvt[1] = parallelMode ? retryEvt[0] :
                       latched_reg[1] & ~trip[1] & autoRetryCh1 &
                       (retry1_reg != retryLimitCh1);
  assign delatch[0]  = (onRise[0] & ~trip[0]) | retryEvt[0];
  assign delatch[1]  = parallelMode ? delatch[0] :
                       (onRise[1] & ~trip[1]) | retryEvt[1];
  assign forceOff    = latched_reg | trip;

  always_ff @(posedge clk) begin
    if (rst) begin
      latched_reg   <= 2'b00;
      retryCountCh0 <= RETRY_ZERO;
      retry1_reg    <= RETRY_ZERO;
    end else begin
      latched_reg <= trip | (latched_reg & ~delatch);
      if (onRise[0] && !trip[0]) begin
        retryCountCh0 <= RETRY_ZERO;
      end else if (retryEvt[0]) begin
        retryCountCh0 <= retryCountCh0 + 4'h1;
      end
      if (onRise[1] && !trip[1]) begin
        retry1_reg <= RETRY_ZERO;
      end else if (retryEvt[1] && !parallelMode) begin
        retry1_reg <= retry1_reg + 4'h1;
      end
    end
  end

  // Channel 1 readback: in parallel mode, copied from channel 0 whenever the two differ
  always_ff @(posedge clk) begin
    if (rst) begin
      retryCountCh1 <= RETRY_ZERO;
    end else if (!parallelMode) begin
      retryCountCh1 <= retry1_reg;
    end else if (retryCountCh1 != retryCountCh0) begin
      retryCountCh1 <= retryCountCh0;
    end
  end

  // Sense ratio of bank 1 taken from bank 0 in parallel mode
  always_ff @(posedge clk) begin
    if (rst) begin
      senseRatioEffCh1 <= 1'b0;
    end else begin
      senseRatioEffCh1 <= parallelMode ? senseRatioCh0 : senseRatioCh1;
    end
  end

  // Flag set vectors; diagnostic bits stay per channel
  assign set0 = {openloadIdleIn[0] & diagCfgCh0[CFG_OLI],
                 openloadActiveIn[0] & diagCfgCh0[CFG_OLA],
                 batteryShortIn[0] & diagCfgCh0[CFG_OS],
                 otEff[0], scEff[0], ocEff[0]};
  assign set1 = {openloadIdleIn[1] & diagCfgCh1[CFG_OLI],
                 openloadActiveIn[1] & diagCfgCh1[CFG_OLA],
                 batteryShortIn[1] & diagCfgCh1[CFG_OS],
                 otEff[1], scEff[1], ocEff[1]};

  // Sticky flags, cleared on read once the cause is gone
  always_ff @(posedge clk) begin
    if (rst) begin
      faultFlagsCh0 <= '0;
      faultFlagsCh1 <= '0;
    end else begin
      faultFlagsCh0 <= flagNext(faultFlagsCh0, set0,
        {FLAG_W{faultRegReadCh0}} & ~{3'b000, ~faultPinN | latched_reg[0], latched_reg[0],
        latched_reg[0]});
      faultFlagsCh1 <= flagNext(faultFlagsCh1, set1,
        {FLAG_W{faultRegReadCh1}} & ~{3'b000, ~faultPinN | latched_reg[1], latched_reg[1],
        latched_reg[1]});
    end
  end

  // Overtemperature hold of the fault pin
  always_ff @(posedge clk) begin
    if (rst) begin
      otHold_reg <= 1'b0;
    end else if (|overtempIn) begin
      otHold_reg <= 1'b1;
    end else if (|(onRise | retryEvt)) begin
      otHold_reg <= 1'b0;
    end
  end

  // Fault pin, active low, real time
  always_ff @(posedge clk) begin
    if (rst) begin
      faultPinN <= 1'b1;
    end else begin
      faultPinN <= ~(|overtempIn | otHold_reg | extBad | extFail_reg |
                     |latched_reg | |trip);
    end
  end

  // Modulators; bank 1 follows bank 0 in parallel mode
  pwm_channel u_ch0 (
    .clk            (clk),
    .rst            (rst),
    .pwmEnable      (pwmEnableCh0),
    .channelOn      (channelOnCh0),
    .forceOff       (forceOff[0]),
    .useExt         (~clockIntCh0),
    .extFallback    (extFail_reg),
    .extTick        (extRise & ~extFail_reg),
    .prescaleDouble (prescaleDoubleCh0),
    .duty           (dutyCh0),
    .intPeriod      (intPeriod),
    .switchOut      (outputCh0)
  );

  pwm_channel u_ch1 (
    .clk            (clk),
    .rst            (rst),
    .pwmEnable      (parallelMode ? pwmEnableCh0 : pwmEnableCh1),
    .channelOn      (parallelMode ? channelOnCh0 : channelOnCh1),
    .forceOff       (forceOff[1]),
    .useExt         (parallelMode ? ~clockIntCh0 : ~clockIntCh1),
    .extFallback    (extFail_reg),
    .extTick        (extRise & ~extFail_reg),
    .prescaleDouble (parallelMode ? prescaleDoubleCh0 : prescaleDoubleCh1),
    .duty           (parallelMode ? dutyCh0 : dutyCh1),
    .intPeriod      (intPeriod),
    .switchOut      (outputCh1)
  );

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ext_fail;
    monitorOn && !extInRange_reg |=> extFail_reg && !faultPinN;
  endproperty
  a_ext_fail: assert property (p_ext_fail) else $error("clock failure not flagged");

  property p_ext_recover;
    $fell(extFail_reg) |-> $past(readSeen_reg) && $past(extInRange_reg);
  endproperty
  a_ext_recover: assert property (p_ext_recover) else $error("early clock recovery");

  property p_cal_reject;
    calState_reg == CAL_MEASURE && csRise && csCnt_reg < CNT_W'(CSB_MIN_CYC)
      |=> $stable(intPeriod);
  endproperty
  a_cal_reject: assert property (p_cal_reject) else $error("bad pulse moved period");

  property p_par_oc;
    parallelMode && |overcurrentIn |=> faultFlagsCh0[OD_OC] && faultFlagsCh1[OD_OC];
  endproperty
  a_par_oc: assert property (p_par_oc) else $error("overcurrent not coupled");

  property p_par_ot;
    parallelMode && |overtempIn |=> ##1 !outputCh0 && !outputCh1;
  endproperty
  a_par_ot: assert property (p_par_ot) else $error("overtemp left channel on");

  property p_ot_pin;
    overtempIn[0] |=> !faultPinN && faultFlagsCh0[OD_OT];
  endproperty
  a_ot_pin: assert property (p_ot_pin) else $error("overtemp not reported");

  property p_ot_clear;
    $fell(faultFlagsCh0[OD_OT]) |-> $past(faultPinN) && !$past(overtempIn[0]);
  endproperty
  a_ot_clear: assert property (p_ot_clear) else $error("overtemp flag cleared early");

  property p_off;
    !channelOnCh0 |=> !outputCh0;
  endproperty
  a_off: assert property (p_off) else $error("channel on with on bit clear");

  property p_retry_mirror;
    parallelMode && $changed(retryCountCh0) |=> retryCountCh1 == $past(retryCountCh0);
  endproperty
  a_retry_mirror: assert property (p_retry_mirror) else $error("retry not mirrored");

  c_cal_ok: cover property (calState_reg == CAL_MEASURE && csRise ##1 $changed(intPeriod));
  c_ext_fail: cover property ($rose(extFail_reg) ##[1:1000] $fell(extFail_reg));
  c_par_oc: cover property (parallelMode && overcurrentIn == 2'b10);
  c_ot_release: cover property ($fell(otHold_reg));
endmodule

/* File: src/pwm_channel.sv */
`timescale 1ns/1ps
module pwm_channel
  import pwm_ctl_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             pwmEnable,
  input  wire logic             channelOn,
  input  wire logic             forceOff,
  input  wire logic             useExt,
  input  wire logic             extFallback,
  input  wire logic             extTick,
  input  wire logic             prescaleDouble,
  input  wire logic [7:0]       duty,
  input  wire logic [CNT_W-1:0] intPeriod,
  output logic                  switchOut
);
  logic [CNT_W-1:0] divCnt_reg;
  logic             phase_reg;
  logic [7:0]       step_reg;
  logic             intTick;
  logic             tick;
  logic             advance;
  logic             run;

  // Tick source selection
  assign intTick = (divCnt_reg == intPeriod - CNT_W'(1));
  assign tick    = useExt ? extTick : intTick;
  assign run     = pwmEnable & ~(useExt & extFallback);
  assign advance = tick & (~(useExt & prescaleDouble) | phase_reg);

  // Internal oscillator divider
  always_ff @(posedge clk) begin
    if (rst || !pwmEnable || intTick) begin
      divCnt_reg <= '0;
    end else begin
      divCnt_reg <= divCnt_reg + CNT_W'(1);
    end
  end

  // Prescale phase and 256-step counter, held at zero while disabled
  always_ff @(posedge clk) begin
    if (rst || !pwmEnable) begin
      phase_reg <= 1'b0;
      step_reg  <= 8'h00;
    end else if (tick) begin
      if (useExt && prescaleDouble) begin
        phase_reg <= ~phase_reg;
      end
      if (advance) begin
        step_reg <= step_reg + 8'h01;
      end
    end
  end

  // Output drive
  always_ff @(posedge clk) begin
    if (rst) begin
      switchOut <= 1'b0;
    end else if (!channelOn || forceOff) begin
      switchOut <= 1'b0;
    end else if (!run) begin
      switchOut <= 1'b1;
    end else begin
      switchOut <= (duty == DUTY_FULL) || (step_reg <= duty);
    end
  end
endmodule

/* File: tb/dual_switch_pwm_clock_parallel_tb.sv */
`timescale 1ns/1ps
module dual_switch_pwm_clock_parallel_tb;
  import pwm_ctl_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic extClock, chipSelectPinN, calibrationCmd;
  logic parallelMode = 1'b0;
  logic channelOnCh0 = 1'b0, channelOnCh1 = 1'b0, pwmEnableCh0 = 1'b0, pwmEnableCh1 = 1'b0;
  logic clockIntCh0 = 1'b0, clockIntCh1 = 1'b0, prescaleDoubleCh0 = 1'b0;
  logic prescaleDoubleCh1 = 1'b0, senseRatioCh0 = 1'b0, senseRatioCh1 = 1'b0;
  logic autoRetryCh0 = 1'b0, autoRetryCh1 = 1'b0;
  logic [7:0] dutyCh0 = 8'h00, dutyCh1 = 8'h00;
  logic [2:0] diagCfgCh0 = 3'h0, diagCfgCh1 = 3'h0;
  logic [3:0] retryLimitCh0 = 4'h0, retryLimitCh1 = 4'h0;
  logic [1:0] overtempIn = 2'h0, overcurrentIn = 2'h0, severeShortIn = 2'h0;
  logic [1:0] batteryShortIn = 2'h0, openloadActiveIn = 2'h0, openloadIdleIn = 2'h0;
  logic faultRegReadCh0 = 1'b0, faultRegReadCh1 = 1'b0, diagRegRead = 1'b0;
  logic outputCh0, outputCh1, faultPinN, extClockFailFlag, senseRatioEffCh1;
  logic [FLAG_W-1:0] faultFlagsCh0, faultFlagsCh1;
  logic [3:0] retryCountCh0, retryCountCh1;
  logic [CNT_W-1:0] intPeriod;
  logic extRun = 1'b0;
  int fails = 0;
  int samplesChecked = 0;
  int cycles = 0;

  dual_switch_pwm_clock_parallel uut (.*);

  mcu_model mcu (
    .clk            (clk),
    .extRun         (extRun),
    .extHalf        (8'h02),
    .extClock       (extClock),
    .chipSelectPinN (chipSelectPinN),
    .calibrationCmd (calibrationCmd)
  );

  // Clock and hang guard
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      finishTest();
    end
  end

  task automatic finishTest();
    if (fails == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic checkBit(input logic got, input logic exp, input string msg);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic checkVal(input logic [CNT_W-1:0] got, input logic [CNT_W-1:0] exp,
                          input string msg);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %0d", $time, msg, got);
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk);
    s = 1'b0;
  endtask

  // Wait bounded for the fault pin level, then judge it
  task automatic waitPin(input logic lvl, input int lim, input string msg);
    for (int i = 0; i < lim && faultPinN !== lvl; i++) @(negedge clk);
    checkBit(faultPinN, lvl, msg);
  endtask

  // High-time counts over n cycles, and cycles where ch0 leads ch1
  task automatic countHigh(input int n, output int c0, output int c1, output int lead);
    c0 = 0;
    c1 = 0;
    lead = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      c0 += int'(outputCh0 === 1'b1);
      c1 += int'(outputCh1 === 1'b1);
      lead += int'(outputCh0 === 1'b1 && outputCh1 !== 1'b1);
    end
    @(negedge clk);
  endtask

  task automatic calibrationTest();
    mcu.calibrate(1500);
    repeat (3) @(negedge clk);
    checkVal(intPeriod, 12'h5DC, "calibrated period");
    // Internal clock, duty 0: first step lasts one calibrated period
    clockIntCh1 = 1'b1;
    channelOnCh1 = 1'b1;
    pwmEnableCh1 = 1'b1;
    repeat (1400) @(negedge clk);
    checkBit(outputCh1, 1'b1, "internal step 0 too short");
    repeat (200) @(negedge clk);
    checkBit(outputCh1, 1'b0, "internal step 0 too long");
    pwmEnableCh1 = 1'b0;
    channelOnCh1 = 1'b0;
    clockIntCh1 = 1'b0;
    mcu.calibrate(800);
    repeat (3) @(negedge clk);
    checkVal(intPeriod, 12'h5DC, "short pulse kept period");
  endtask

  task automatic extDutyTest();
    int c0, c1, lead;
    extRun = 1'b1;
    channelOnCh0 = 1'b1;
    channelOnCh1 = 1'b1;
    dutyCh0 = 8'h03;
    dutyCh1 = 8'h07;
    // Let the monitor see two good edges before it is armed
    repeat (12) @(negedge clk);
    pwmEnableCh0 = 1'b1;
    pwmEnableCh1 = 1'b1;
    repeat (1100) @(negedge clk);
    countHigh(1024, c0, c1, lead);
    checkVal(CNT_W'(c0), 12'h010, "ch0 on-time div 256");
    checkVal(CNT_W'(c1), 12'h020, "ch1 on-time div 256");
    checkVal(CNT_W'(lead), 12'h000, "channels not aligned");
    prescaleDoubleCh0 = 1'b1;
    dutyCh1 = DUTY_FULL;
    repeat (2100) @(negedge clk);
    countHigh(2048, c0, c1, lead);
    checkVal(CNT_W'(c0), 12'h020, "ch0 on-time div 512");
    checkVal(CNT_W'(c1), 12'h800, "full duty not on");
    channelOnCh1 = 1'b0;
    repeat (3) @(negedge clk);
    countHigh(1024, c0, c1, lead);
    checkVal(CNT_W'(c1), 12'h000, "off channel switching");
  endtask

  task automatic extFailTest();
    pwmEnableCh0 = 1'b0;
    pwmEnableCh1 = 1'b0;
    extRun = 1'b0;
    repeat (200) @(negedge clk);
    checkBit(faultPinN, 1'b1, "monitor active while disabled");
    pwmEnableCh0 = 1'b1;
    waitPin(1'b0, 150, "stopped clock not flagged");
    repeat (3) @(negedge clk);
    checkBit(extClockFailFlag, 1'b1, "clock failure flag");
    checkBit(outputCh0, 1'b1, "output not following on bit");
    extRun = 1'b1;
    repeat (300) @(negedge clk);
    checkBit(faultPinN, 1'b0, "released before flag read");
    pulse(diagRegRead);
    waitPin(1'b1, 300, "no recovery after read");
  endtask

  task automatic overtempTest();
    dutyCh0 = DUTY_FULL;
    overtempIn = 2'b01;
    repeat (3) @(negedge clk);
    checkBit(outputCh0, 1'b0, "hot channel still on");
    checkBit(faultFlagsCh0[OD_OT], 1'b1, "overtemp flag");
    checkBit(faultPinN, 1'b0, "overtemp pin");
    overtempIn = 2'b00;
    repeat (3) @(negedge clk);
    checkBit(faultPinN, 1'b0, "pin released without turn-on");
    pulse(faultRegReadCh0);
    repeat (2) @(negedge clk);
    checkBit(faultFlagsCh0[OD_OT], 1'b1, "flag cleared with pin low");
    channelOnCh0 = 1'b0;
    @(negedge clk);
    channelOnCh0 = 1'b1;
    repeat (4) @(negedge clk);
    checkBit(faultPinN, 1'b1, "pin held after turn-on");
    pulse(faultRegReadCh0);
    repeat (2) @(negedge clk);
    checkBit(faultFlagsCh0[OD_OT], 1'b0, "flag not cleared by read");
  endtask

  task automatic parallelTest();
    parallelMode = 1'b1;
    senseRatioCh0 = 1'b1;
    diagCfgCh1 = 3'h4;
    batteryShortIn = 2'b11;
    repeat (3) @(negedge clk);
    checkBit(senseRatioEffCh1, 1'b1, "sense ratio not copied");
    checkBit(faultFlagsCh0[OD_OS], 1'b0, "ch0 short flag ungated");
    checkBit(faultFlagsCh1[OD_OS], 1'b1, "ch1 short flag missing");
    batteryShortIn = 2'b00;
    overcurrentIn = 2'b10;
    repeat (2) @(negedge clk);
    overcurrentIn = 2'b00;
    repeat (2) @(negedge clk);
    checkBit(faultFlagsCh0[OD_OC], 1'b1, "ch0 overcurrent flag");
    checkBit(faultFlagsCh1[OD_OC], 1'b1, "ch1 overcurrent flag");
    checkBit(outputCh0, 1'b0, "ch0 not turned off");
    checkBit(outputCh1, 1'b0, "ch1 not turned off");
    // One retry of channel 0 delatches both and is mirrored
    retryLimitCh0 = 4'h3;
    autoRetryCh0 = 1'b1;
    repeat (3) @(negedge clk);
    checkVal(CNT_W'(retryCountCh0), 12'h001, "ch0 retry count");
    checkVal(CNT_W'(retryCountCh1), 12'h001, "retry not mirrored");
    checkBit(outputCh1, 1'b1, "ch1 not delatched by ch0");
    overtempIn = 2'b10;
    repeat (3) @(negedge clk);
    checkBit(faultFlagsCh0[OD_OT], 1'b1, "ch0 overtemp flag not coupled");
    checkBit(outputCh0, 1'b0, "ch0 on after ch1 overtemp");
    checkBit(outputCh1, 1'b0, "ch1 on after overtemp");
  endtask

  // Main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    checkBit(faultPinN, 1'b1, "pin after reset");
    checkVal(intPeriod, INT_PERIOD_DEF, "default period");
    calibrationTest();
    extDutyTest();
    extFailTest();
    overtempTest();
    parallelTest();
    finishTest();
  end
endmodule

/* File: tb/mcu_model.sv */
`timescale 1ns/1ps
module mcu_model (
  input  wire logic       clk,
  input  wire logic       extRun,
  input  wire logic [7:0] extHalf,
  output logic            extClock,
  output logic            chipSelectPinN,
  output logic            calibrationCmd
);
  int extCnt;

  // Idle levels: clock parked low, select released high
  initial begin
    extClock = 1'b0;
    chipSelectPinN = 1'b1;
    calibrationCmd = 1'b0;
    extCnt = 0;
  end

  // External clock toggles every extHalf cycles, stands still when stopped
  always @(negedge clk) begin
    if (!extRun) begin
      extCnt <= 0;
    end else if (extCnt + 1 >= int'(extHalf)) begin
      extCnt <= 0;
      extClock <= ~extClock;
    end else begin
      extCnt <= extCnt + 1;
    end
  end

  // Command word, then one low select pulse of the given length
  task automatic calibrate(input int len);
    @(negedge clk);
    calibrationCmd = 1'b1;
    @(negedge clk);
    calibrationCmd = 1'b0;
    repeat (2) @(negedge clk);
    chipSelectPinN = 1'b0;
    repeat (len) @(negedge clk);
    chipSelectPinN = 1'b1;
  endtask
endmodule
